// ===== common/ied_pkg.sv
package ied_pkg;
  // ---------------------------------------------------------------
  // widths, flag bits, reset values
  // ---------------------------------------------------------------
  localparam int IF_BIT = 9;
  localparam int OF_BIT = 11;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0002;
  localparam logic [31:0] RST_IP = 32'h0000_0000;
  localparam logic [31:0] RST_SP = 32'h0000_0000;
  localparam logic [15:0] RST_SEL = 16'h0000;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  // ---------------------------------------------------------------
  // vectors
  // ---------------------------------------------------------------
  localparam logic [7:0] V_QUOT = 8'h00;
  localparam logic [7:0] V_DEBUG = 8'h01;
  localparam logic [7:0] V_NMI = 8'h02;
  localparam logic [7:0] V_BRK = 8'h03;
  localparam logic [7:0] V_OVF = 8'h04;
  localparam logic [7:0] V_RANGE = 8'h05;
  localparam logic [7:0] V_DOUBLE = 8'h08;
  localparam logic [7:0] V_PROT = 8'h0D;
  localparam logic [7:0] V_USER_LO = 8'h20;
  // fault bus bits the execution unit may raise: 0,1,6-8,10-14,16-20
  localparam logic [31:0] FAULT_OK = 32'h001F_7DC3;
  // vectors that push an error code word: 8,10-14,17
  localparam logic [31:0] ERR_MASK = 32'h0002_7D00;
  // frame sizes in words, without error code
  localparam logic [2:0] FRAME_SAME = 3'h3;
  localparam logic [2:0] FRAME_SWITCH = 3'h5;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {GK_MASKABLE_REQUEST_PIN, GK_TRAP, GK_TASK} ied_gate_e;
  typedef enum logic [2:0] {
    IO_NONE, IO_SOFT, IO_OVF, IO_BRK, IO_RANGE, IO_RET
  } ied_op_e;
  typedef struct packed {
    ied_gate_e kind;
    logic [15:0] sel;
    logic [31:0] offs;
    logic [1:0] dpl;
  } ied_gate_s;
  typedef struct packed {
    logic valid;
    ied_op_e op;
    logic [7:0] vec;
    logic out_of_range;
  } ied_instr_s;
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] ip;
    logic [31:0] sp;
    logic [15:0] cs;
    logic [15:0] ss;
  } ied_arch_s;
  typedef struct packed {
    logic [15:0] ss;
    logic [31:0] sp;
  } ied_stack_s;
endpackage

// ===== hdl/ied_dispatch.sv
`timescale 1ns/1ps
module ied_dispatch import ied_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_nmi_pin,
  input wire logic i_mask_pin,
  input wire logic [7:0] i_ext_vec,
  input wire logic [31:0] i_fault,
  input wire logic [31:0] i_fault_code,
  input wire ied_instr_s i_instr,
  input wire logic i_real_mode,
  input wire ied_gate_s i_gate,
  input wire ied_stack_s i_tss,
  input wire logic i_push_ready,
  input wire logic [31:0] i_pop_data,
  input wire logic i_pop_valid,
  input wire logic i_task_done,
  input wire ied_arch_s i_task_arch,
  output logic [7:0] o_tbl_vec,
  output logic [1:0] o_tss_level,
  output logic o_push_valid,
  output logic [47:0] o_push_addr,
  output logic [31:0] o_push_data,
  output logic o_pop_req,
  output logic [47:0] o_pop_addr,
  output logic o_task_req,
  output logic o_task_back,
  output logic [15:0] o_task_sel,
  output ied_arch_s o_arch,
  output logic o_busy,
  output logic o_int_ack
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // lowest set bit wins: lower vectors carry higher priority
  function automatic logic [7:0] first_bit(input logic [31:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 31; k >= 0; k--) begin
      if (v[k]) begin
        r = 8'(k);
      end
    end
    return r;
  endfunction

  function automatic logic has_err(input logic [7:0] v);
    return (v < V_USER_LO) && ERR_MASK[v[4:0]];
  endfunction

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_GATE = 5'b00010,
    S_PUSH = 5'b00100,
    S_TASK = 5'b01000,
    S_POP = 5'b10000
  } ied_state_e;

  ied_state_e st_q;
  ied_arch_s arch_q;
  ied_arch_s held_q;
  logic [7:0] vec_q;
  logic err_q;
  logic [31:0] code_q;
  logic sw_q;
  logic maskable_request_pin_gate_q;
  logic [2:0] idx_q;
  logic [2:0] last_q;
  logic [15:0] sel_q;
  logic [31:0] offs_q;
  logic task_nest_q;
  logic df_pend_q;
  logic [31:0] p_ip_q;
  logic [15:0] p_cs_q;
  logic [31:0] p_fl_q;
  logic [31:0] p_sp_q;
  logic [2:0] nmi_sync_q;
  logic [1:0] mask_sync_q;
  logic nmi_pend_q;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // pins are asynchronous: two flops before any logic looks at them
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      nmi_sync_q <= 3'h0;
      mask_sync_q <= 2'h0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], i_nmi_pin};
      mask_sync_q <= {mask_sync_q[0], i_mask_pin};
    end
  end

  // ---------------------------------------------------------------
  // event selection
  // ---------------------------------------------------------------
  logic nmi_rise;
  logic [31:0] flt;
  logic mask_req;
  logic cpl_lt;
  assign nmi_rise = nmi_sync_q[1] & ~nmi_sync_q[2];
  assign flt = i_fault & FAULT_OK;
  assign mask_req = mask_sync_q[1] & arch_q.flags[IF_BIT];
  assign cpl_lt = p_cs_q[1:0] < arch_q.cs[1:0];

  logic take;
  logic [7:0] take_vec;
  logic take_err;
  logic take_ack;
  always_comb begin
    take = 1'b1;
    take_err = 1'b0;
    take_ack = 1'b0;
    take_vec = V_DOUBLE;
    if (df_pend_q) begin
      take_err = 1'b1;
    end else if (|flt) begin
      take_vec = first_bit(flt);
      take_err = has_err(take_vec);
    end else if (nmi_pend_q) begin
      take_vec = V_NMI;
    end else if (i_instr.valid && i_instr.op == IO_SOFT) begin
      take_vec = i_instr.vec;
    end else if (i_instr.valid && i_instr.op == IO_BRK) begin
      take_vec = V_BRK;
    end else if (i_instr.valid && i_instr.op == IO_OVF &&
                 arch_q.flags[OF_BIT]) begin
      take_vec = V_OVF;
    end else if (i_instr.valid && i_instr.op == IO_RANGE &&
                 i_instr.out_of_range) begin
      take_vec = V_RANGE;
    end else if (mask_req) begin
      take_vec = i_ext_vec;
      take_ack = 1'b1;
    end else begin
      take = 1'b0;
    end
  end

  logic go_ret;
  assign go_ret = i_instr.valid && i_instr.op == IO_RET && !take;

  // ---------------------------------------------------------------
  // pending latches: a new event beats the clear
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_rise) begin
      nmi_pend_q <= 1'b1;
    end else if (st_q == S_IDLE && take && !df_pend_q && !(|flt)) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // a fault while a frame is being built escalates to vector 8
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      df_pend_q <= 1'b0;
    end else if (st_q != S_IDLE && |flt) begin
      df_pend_q <= 1'b1;
    end else if (st_q == S_IDLE) begin
      df_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // frame word for each push slot
  // ---------------------------------------------------------------
  logic [2:0] slot;
  assign slot = sw_q ? idx_q : idx_q + 3'h2;
  always_comb begin
    case (slot)
      3'h0: o_push_data = {16'h0000, held_q.ss};
      3'h1: o_push_data = held_q.sp;
      3'h2: o_push_data = held_q.flags;
      3'h3: o_push_data = {16'h0000, held_q.cs};
      3'h4: o_push_data = held_q.ip;
      default: o_push_data = code_q;
    endcase
  end

  logic [31:0] sp_dn;
  logic [31:0] sp_up;
  assign sp_dn = arch_q.sp - WORD_BYTES;
  assign sp_up = arch_q.sp + WORD_BYTES;
  assign o_push_valid = st_q == S_PUSH;
  assign o_push_addr = {arch_q.ss, sp_dn};
  assign o_pop_req = st_q == S_POP;
  assign o_pop_addr = {arch_q.ss, arch_q.sp};
  assign o_tbl_vec = vec_q;
  assign o_tss_level = i_gate.dpl;
  assign o_busy = st_q != S_IDLE;
  assign o_arch = arch_q;
  assign o_task_sel = sel_q;

  // ---------------------------------------------------------------
  // dispatch sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_q <= S_IDLE;
      idx_q <= 3'h0;
      last_q <= 3'h0;
      vec_q <= 8'h00;
      err_q <= 1'b0;
      code_q <= 32'h0000_0000;
      sw_q <= 1'b0;
      maskable_request_pin_gate_q <= 1'b0;
      sel_q <= RST_SEL;
      offs_q <= RST_IP;
      held_q <= '{RST_FLAGS, RST_IP, RST_SP, RST_SEL, RST_SEL};
      o_task_req <= 1'b0;
      o_task_back <= 1'b0;
      o_int_ack <= 1'b0;
      task_nest_q <= 1'b0;
    end else begin
      o_task_req <= 1'b0;
      o_int_ack <= 1'b0;
      case (st_q)
        S_IDLE: begin
          idx_q <= 3'h0;
          held_q <= arch_q;
          if (take) begin
            vec_q <= take_vec;
            err_q <= take_err;
            code_q <= i_fault_code;
            o_int_ack <= take_ack;
            st_q <= S_GATE;
          end else if (go_ret && task_nest_q) begin
            o_task_req <= 1'b1;
            o_task_back <= 1'b1;
            st_q <= S_TASK;
          end else if (go_ret) begin
            st_q <= S_POP;
          end
        end
        S_GATE: begin
          sel_q <= i_gate.sel;
          offs_q <= i_gate.offs;
          maskable_request_pin_gate_q <= i_real_mode || i_gate.kind == GK_MASKABLE_REQUEST_PIN;
          sw_q <= !i_real_mode && i_gate.dpl < arch_q.cs[1:0];
          if (!i_real_mode && i_gate.dpl < arch_q.cs[1:0]) begin
            last_q <= FRAME_SWITCH - {2'b00, ~err_q};
          end else begin
            last_q <= FRAME_SAME - {2'b00, ~err_q};
          end
          if (!i_real_mode && i_gate.kind == GK_TASK) begin
            o_task_req <= 1'b1;
            o_task_back <= 1'b0;
            st_q <= S_TASK;
          end else begin
            st_q <= S_PUSH;
          end
        end
        S_PUSH: begin
          if (i_push_ready) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == last_q) begin
              st_q <= S_IDLE;
            end
          end
        end
        S_TASK: begin
          if (i_task_done) begin
            task_nest_q <= !o_task_back;
            st_q <= S_IDLE;
          end
        end
        S_POP: begin
          if (i_pop_valid) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h2 &&
                (i_real_mode || p_cs_q[1:0] == arch_q.cs[1:0])) begin
              st_q <= S_IDLE;
            end else if (idx_q == 3'h2 && cpl_lt) begin
              vec_q <= V_PROT;
              err_q <= 1'b1;
              code_q <= {16'h0000, p_cs_q};
              st_q <= S_GATE;
            end else if (idx_q == 3'h4) begin
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // return frame capture: ip, cs, flags, sp; ss goes straight from i_pop_data into the state
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      p_ip_q <= RST_IP;
      p_cs_q <= RST_SEL;
      p_fl_q <= RST_FLAGS;
      p_sp_q <= RST_SP;
    end else if (st_q == S_POP && i_pop_valid) begin
      case (idx_q)
        3'h0: p_ip_q <= i_pop_data;
        3'h1: p_cs_q <= i_pop_data[15:0];
        3'h2: p_fl_q <= i_pop_data;
        3'h3: p_sp_q <= i_pop_data;
        default: p_ip_q <= p_ip_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // architectural state
  // ---------------------------------------------------------------
  // the handler entry lands with the last push so no bubble is spent
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      arch_q <= '{RST_FLAGS, RST_IP, RST_SP, RST_SEL, RST_SEL};
    end else begin
      case (st_q)
        S_GATE: begin
          if (!i_real_mode && i_gate.kind != GK_TASK &&
              i_gate.dpl < arch_q.cs[1:0]) begin
            arch_q.ss <= i_tss.ss;
            arch_q.sp <= i_tss.sp;
          end
        end
        S_PUSH: begin
          if (i_push_ready) begin
            arch_q.sp <= sp_dn;
            if (idx_q == last_q) begin
              arch_q.cs <= sel_q;
              arch_q.ip <= offs_q;
              if (maskable_request_pin_gate_q) begin
                arch_q.flags[IF_BIT] <= 1'b0;
              end // trap gate outside real mode: flag untouched
            end
          end
        end
        S_TASK: begin
          if (i_task_done) begin
            arch_q <= i_task_arch;
          end
        end
        S_POP: begin
          if (i_pop_valid) begin
            arch_q.sp <= sp_up;
            if (idx_q == 3'h2 &&
                (i_real_mode || p_cs_q[1:0] == arch_q.cs[1:0])) begin
              arch_q.ip <= p_ip_q;
              arch_q.cs <= p_cs_q;
              arch_q.flags <= i_pop_data;
            end else if (idx_q == 3'h2 && cpl_lt) begin
              arch_q.sp <= arch_q.sp; // frame stays for the fault
            end else if (idx_q == 3'h4) begin
              arch_q.ip <= p_ip_q;
              arch_q.cs <= p_cs_q;
              arch_q.flags <= p_fl_q;
              arch_q.sp <= p_sp_q;
              arch_q.ss <= i_pop_data[15:0];
            end
          end
        end
        default: arch_q <= arch_q;
      endcase
    end
  end

endmodule

// ===== verification/ied_dispatch_asserts.sv
`timescale 1ns/1ps
module ied_dispatch_asserts import ied_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_nmi_pin,
  input wire logic i_mask_pin,
  input wire logic [31:0] i_fault,
  input wire ied_instr_s i_instr,
  input wire ied_gate_s i_gate,
  input wire logic i_push_ready,
  input wire logic [7:0] o_tbl_vec,
  input wire logic o_push_valid,
  input wire logic [47:0] o_push_addr,
  input wire logic [31:0] o_push_data,
  input wire logic o_task_req,
  input wire ied_arch_s o_arch,
  input wire logic o_busy,
  input wire logic o_int_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // --------
  // sequences
  // --------
  // idle, no pins: only the bus under test can start work
  sequence s_idle;
    !o_busy && !i_nmi_pin && !i_mask_pin;
  endsequence
  sequence s_op(ied_op_e o);
    s_idle ##0 (i_fault == '0 && i_instr.valid && i_instr.op == o);
  endsequence
  sequence s_push;
    o_push_valid && i_push_ready;
  endsequence
  // --------
  // properties
  // --------
  a_soft_vec: assert property (
    s_op(IO_SOFT) |=> o_busy && o_tbl_vec == $past(i_instr.vec))
    else $error("soft call vector wrong");
  a_brk_vec: assert property (
    s_op(IO_BRK) |=> o_tbl_vec == 8'h03)
    else $error("breakpoint vector wrong");
  a_ovf_quiet: assert property (
    s_op(IO_OVF) ##0 !o_arch.flags[OF_BIT] |=> !o_busy)
    else $error("overflow trap without flag");
  a_range_quiet: assert property (
    s_op(IO_RANGE) ##0 !i_instr.out_of_range |=> !o_busy)
    else $error("range fault in range");
  a_resv_fault: assert property (
    s_idle ##0 (!i_instr.valid && i_fault != '0 &&
    (i_fault & FAULT_OK) == '0) |=> !o_busy)
    else $error("reserved fault taken");
  a_prot_vec: assert property (
    s_idle ##0 (i_fault[13:0] == 14'h2000) |=> o_tbl_vec == 8'h0D)
    else $error("protection vector wrong");
  a_ack_user: assert property (
    o_int_ack |-> o_tbl_vec >= 8'h20)
    else $error("maskable vector below 32");
  a_if_maskable_request_pin: assert property (
    $fell(o_busy) && $past(o_push_valid) && i_gate.kind == GK_MASKABLE_REQUEST_PIN
    |-> !o_arch.flags[IF_BIT])
    else $error("enable not cleared");
  a_if_trap: assert property (
    $fell(o_busy) && $past(o_push_valid) && i_gate.kind == GK_TRAP
    |-> o_arch.flags[IF_BIT] == $past(o_arch.flags[IF_BIT]))
    else $error("enable changed");
  a_push_step: assert property (
    s_push ##1 o_push_valid
    |-> o_push_addr[31:0] == $past(o_push_addr[31:0]) - WORD_BYTES)
    else $error("push not one word down");
  a_push_hold: assert property (
    o_push_valid && !i_push_ready |=> o_push_valid &&
    $stable(o_push_addr) && $stable(o_push_data))
    else $error("stalled push moved");
  a_task_pulse: assert property (
    o_task_req |=> !o_task_req)
    else $error("task request too long");
endmodule

bind ied_dispatch ied_dispatch_asserts u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn),
  .i_nmi_pin(i_nmi_pin), .i_mask_pin(i_mask_pin), .i_fault(i_fault),
  .i_instr(i_instr), .i_gate(i_gate), .i_push_ready(i_push_ready),
  .o_tbl_vec(o_tbl_vec), .o_push_valid(o_push_valid),
  .o_push_addr(o_push_addr), .o_push_data(o_push_data),
  .o_task_req(o_task_req), .o_arch(o_arch), .o_busy(o_busy),
  .o_int_ack(o_int_ack));

// ===== verification/ied_partner.sv
`timescale 1ns/1ps
module ied_partner import ied_pkg::*; (
  input wire logic i_clk,
  input wire ied_gate_e i_kind,
  input wire logic [1:0] i_dpl,
  input wire logic i_slow,
  input wire logic [7:0] i_vec,
  input wire logic i_push_valid,
  input wire logic [47:0] i_push_addr,
  input wire logic [31:0] i_push_data,
  input wire logic i_pop_req,
  input wire logic [47:0] i_pop_addr,
  input wire logic i_task_req,
  input wire logic i_task_back,
  input wire ied_arch_s i_arch,
  output ied_gate_s o_gate,
  output ied_stack_s o_tss,
  output logic o_push_ready,
  output logic [31:0] o_pop_data,
  output logic o_pop_valid,
  output logic o_task_done,
  output ied_arch_s o_task_arch
);
  logic [31:0] mem [logic [47:0]];
  logic [79:0] pq [$];
  logic tg = 1'b0;
  ied_arch_s saved_arch = '0;
  // --------
  // tables
  // --------
  // entry point derived from the vector so each handler is distinct
  assign o_gate = '{i_kind, {6'h00, i_vec, i_dpl}, {24'h000010, i_vec}, i_dpl};
  assign o_tss = '{16'h0010, 32'h0000_0400};
  // entry hands over a fixed task state, the way back the saved one
  assign o_task_arch = i_task_back ? saved_arch :
    ied_arch_s'{32'h202, 32'h777, 32'h900, 16'h8, 16'h10};
  // slow mode accepts every other cycle to exercise stalls
  assign o_push_ready = i_push_valid & (~i_slow | tg);
  // preloaded frame returning to a level 3 caller
  initial begin
    mem[48'h0] = 32'h0000_0100;
    mem[48'h4] = 32'h0000_0023;
    mem[48'h8] = 32'h0000_0202;
    mem[48'hC] = 32'h0000_0800;
    mem[48'h10] = 32'h0000_002B;
    o_pop_valid = 1'b0;
    o_task_done = 1'b0;
    o_pop_data = 32'h0;
  end
  // memory cycle; unwritten words read as the inverse of the last one
  always @(posedge i_clk) begin
    tg <= ~tg;
    o_task_done <= i_task_req;
    if (i_task_req && !i_task_back) begin
      saved_arch <= i_arch;
    end
    o_pop_valid <= i_pop_req & ~o_pop_valid;
    o_pop_data <= mem.exists(i_pop_addr) ? mem[i_pop_addr] : ~o_pop_data;
    if (o_push_ready) begin
      mem[i_push_addr] = i_push_data;
      pq.push_back({i_push_addr, i_push_data});
    end
  end
endmodule

// ===== verification/ied_dispatch_test.sv
`timescale 1ns/1ps
module ied_dispatch_test import ied_pkg::*; ;
  logic clk, resetn, nmi, mask, rdy, pv, td, preq, pvld, treq, busy, ack;
  logic slow = 1'b0;
  logic rmode = 1'b0;
  logic tback;
  logic [1:0] tlvl;
  logic [15:0] tsel;
  logic [1:0] dpl = 2'h0;
  logic [7:0] ext_vec = 8'h41;
  logic [7:0] tvec;
  logic [31:0] fault, code, pd, pdat;
  logic [47:0] paddr, qaddr;
  ied_gate_e kind = GK_TRAP;
  ied_instr_s instr;
  ied_gate_s gate;
  ied_stack_s task_state_segment;
  ied_arch_s tarch, arch;
  int err_total = 0;
  int checks = 0;

  ied_dispatch DUT (.i_clk(clk), .i_resetn(resetn), .i_nmi_pin(nmi),
    .i_mask_pin(mask), .i_ext_vec(ext_vec), .i_fault(fault),
    .i_fault_code(code), .i_instr(instr), .i_real_mode(rmode),
    .i_gate(gate), .i_tss(task_state_segment), .i_push_ready(rdy), .i_pop_data(pd),
    .i_pop_valid(pv), .i_task_done(td), .i_task_arch(tarch),
    .o_tbl_vec(tvec), .o_tss_level(tlvl), .o_push_valid(pvld),
    .o_push_addr(paddr), .o_push_data(pdat), .o_pop_req(preq),
    .o_pop_addr(qaddr), .o_task_req(treq), .o_task_back(tback),
    .o_task_sel(tsel), .o_arch(arch), .o_busy(busy), .o_int_ack(ack));
  ied_partner p (.i_clk(clk), .i_kind(kind), .i_dpl(dpl), .i_slow(slow),
    .i_vec(tvec), .i_push_valid(pvld), .i_push_addr(paddr),
    .i_push_data(pdat), .i_pop_req(preq), .i_pop_addr(qaddr),
    .i_task_req(treq), .i_task_back(tback), .i_arch(arch),
    .o_gate(gate), .o_tss(task_state_segment), .o_push_ready(rdy),
    .o_pop_data(pd), .o_pop_valid(pv), .o_task_done(td),
    .o_task_arch(tarch));

  // --------
  // helpers
  // --------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // inputs always change 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait: start of work, then end of work
  task automatic settle();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    while (busy !== 1'b0 && n < 80) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic poke(input ied_op_e o, input logic [7:0] v, input logic r);
    instr = '{1'b1, o, v, r};
    cyc(1);
    instr = '0;
  endtask
  task automatic op(input ied_op_e o, input logic [7:0] v, input logic r);
    p.pq.delete();
    poke(o, v, r);
    settle();
  endtask

  // --------
  // scenarios
  // --------
  task automatic t_xret();
    op(IO_RET, 8'h0, 1'b0);
    chk(arch, {32'h202, 32'h100, 32'h800, 16'h23, 16'h2B});
  endtask
  task automatic t_faults();
    dpl = 2'h3;
    for (int v = 0; v < 21; v++) begin
      if (FAULT_OK[v]) begin
        p.pq.delete();
        fault = 32'h1 << v;
        code = 32'hC0DE_0000 | v;
        cyc(1);
        fault = '0;
        settle();
        chk(tvec, v);
        chk(p.pq.size(), 3 + ERR_MASK[v]);
        chk(p.pq[0][31:0], 32'h0000_0202);
        if (ERR_MASK[v]) chk(p.pq[3][31:0], code);
      end
    end
    fault = ~FAULT_OK;
    cyc(1);
    fault = '0;
    chk(busy, 1'b0);
  endtask
  task automatic t_instr();
    poke(IO_OVF, 8'h0, 1'b0);
    chk(busy, 1'b0);
    poke(IO_RANGE, 8'h0, 1'b0);
    chk(busy, 1'b0);
    op(IO_SOFT, 8'h04, 1'b0);
    chk(tvec, 8'h04);
    op(IO_SOFT, 8'h05, 1'b0);
    chk(tvec, 8'h05);
    op(IO_RANGE, 8'h0, 1'b1);
    chk(tvec, 8'h05);
    nmi = 1'b1;
    cyc(4);
    nmi = 1'b0;
    settle();
    chk(tvec, 8'h02);
  endtask
  // same level: frame on the current stack, return undoes it
  task automatic t_same();
    ied_arch_s a0;
    a0 = arch;
    op(IO_BRK, 8'h0, 1'b0);
    chk(tvec, 8'h03);
    chk(arch.sp, a0.sp - 32'hC);
    chk(arch.flags, a0.flags);
    chk(p.pq[1][31:0], {16'h0, a0.cs});
    op(IO_RET, 8'h0, 1'b0);
    chk(arch, a0);
  endtask
  // more privileged handler with a stalling memory
  task automatic t_switch();
    ied_arch_s a0, e;
    logic [31:0] w [5];
    a0 = arch;
    w = '{{16'h0, a0.ss}, a0.sp, a0.flags, {16'h0, a0.cs}, a0.ip};
    kind = GK_MASKABLE_REQUEST_PIN;
    dpl = 2'h0;
    slow = 1'b1;
    op(IO_SOFT, 8'h40, 1'b0);
    chk(tlvl, 2'h0);
    chk(p.pq.size(), 5);
    for (int i = 0; i < 5; i++) begin
      chk(p.pq[i], {16'h0010, 32'h3FC - 4 * i, w[i]});
    end
    e = '{a0.flags & ~32'h200, 32'h1040, 32'h3EC, 16'h100, 16'h10};
    chk(arch, e);
    op(IO_RET, 8'h0, 1'b0);
    chk(arch, a0);
    slow = 1'b0;
  endtask
  task automatic t_mask();
    int n;
    dpl = 2'h3;
    mask = 1'b1;
    n = 0;
    while (ack !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(ack, 1'b1);
    mask = 1'b0;
    settle();
    chk(tvec, 8'h41);
    chk(arch.flags[IF_BIT], 1'b0);
    op(IO_RET, 8'h0, 1'b0);
  endtask
  // real mode: pointer table entry, no stack switch even to level 0
  task automatic t_real();
    ied_arch_s a0, e;
    a0 = arch;
    e = '{a0.flags & ~32'h200, 32'h1022, a0.sp - 32'hC, 16'h88, a0.ss};
    dpl = 2'h0;
    rmode = 1'b1;
    op(IO_SOFT, 8'h22, 1'b0);
    chk(arch, e);
    chk(p.pq.size(), 3);
    chk(p.pq[0][31:0], a0.flags);
    chk(p.pq[1][31:0], {16'h0, a0.cs});
    chk(p.pq[2][31:0], a0.ip);
    op(IO_RET, 8'h0, 1'b0);
    chk(arch, a0);
    rmode = 1'b0;
  endtask
  // task gate: state handed over, saved state back on return
  task automatic t_task();
    ied_arch_s a0;
    a0 = arch;
    kind = GK_TASK;
    dpl = 2'h3;
    op(IO_SOFT, 8'h30, 1'b0);
    chk(tsel, 16'h00C3);
    chk(tback, 1'b0);
    chk(p.pq.size(), 0);
    chk(arch, {32'h202, 32'h777, 32'h900, 16'h8, 16'h10});
    op(IO_RET, 8'h0, 1'b0);
    chk(tback, 1'b1);
    chk(arch, a0);
  endtask
  // fault while a frame is built: vector 8 follows with its code
  task automatic t_dbl();
    kind = GK_TRAP;
    code = 32'h0000_0D0F;
    p.pq.delete();
    poke(IO_SOFT, 8'h21, 1'b0);
    fault = 32'h1;
    cyc(1);
    fault = '0;
    settle();
    settle();
    chk(tvec, 8'h08);
    chk(p.pq.size(), 7);
    chk(p.pq[6][31:0], code);
  endtask

  // clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cut a hang short at 50000 cycles, far beyond the few hundred cycles needed
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    nmi = 1'b0;
    mask = 1'b0;
    fault = '0;
    code = '0;
    instr = '0;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    cyc(2);
    t_xret();
    t_faults();
    t_instr();
    t_same();
    t_switch();
    t_mask();
    t_real();
    t_task();
    t_dbl();
    give_verdict();
  end
endmodule
